// >>> subghz_tx_pkg.sv
// shared constants and types for the sub-GHz transmitter host block
// assumes one 40 MHz system clock and 8-bit registers at 5-bit addresses
package subghz_tx_pkg;
  typedef enum logic [2:0] {
    MODE_PRESET = 3'b001,
    MODE_I2C    = 3'b010,
    MODE_SPI    = 3'b100
  } bus_mode_t;
  typedef enum logic [3:0] {
    I2C_IDLE  = 4'b0001,
    I2C_ADDR  = 4'b0010,
    I2C_WRITE = 4'b0100,
    I2C_READ  = 4'b1000
  } i2c_state_t;
  // register addresses
  localparam logic [4:0] ADDR_BASE_CFG  = 5'h00;
  localparam logic [4:0] ADDR_BAUD_POST = 5'h01;
  localparam logic [4:0] ADDR_BAUD_PRE  = 5'h02;
  localparam logic [4:0] ADDR_PWR_DOWN  = 5'h03;
  localparam logic [4:0] ADDR_AMP       = 5'h06;
  localparam logic [4:0] ADDR_TXEN_A    = 5'h0a;
  localparam logic [4:0] ADDR_TXEN_B    = 5'h0b;
  localparam logic [4:0] ADDR_PKT_LEN   = 5'h11;
  localparam logic [4:0] ADDR_FIFO_WIN  = 5'h12;
  localparam logic [4:0] ADDR_RB_A      = 5'h14;
  localparam logic [4:0] ADDR_RB_B      = 5'h15;
  localparam logic [4:0] ADDR_RB_C      = 5'h16;
  localparam logic [4:0] ADDR_ID        = 5'h1b;
  localparam logic [4:0] ADDR_REV       = 5'h1c;
  localparam logic [4:0] ADDR_STATUS    = 5'h1d;
  // field positions
  localparam int MOD_FSK_BIT   = 0;
  localparam int TXEN_BIT      = 0;
  localparam int ST_TX_BIT     = 0;
  localparam int ST_UNDER_BIT  = 1;
  localparam int ST_OVER_BIT   = 2;
  localparam int ST_EMPTY_BIT  = 3;
  localparam int ST_FULL_BIT   = 4;
  // bus address bytes
  localparam logic [7:0] I2C_ADDR_WR = 8'hd2;
  localparam logic [7:0] I2C_ADDR_RD = 8'hd3;
  // power states on o_power_mode
  localparam logic [1:0] PWR_SHUTDOWN = 2'h0;
  localparam logic [1:0] PWR_STANDBY  = 2'h1;
  localparam logic [1:0] PWR_PROGRAM  = 2'h2;
  localparam logic [1:0] PWR_TRANSMIT = 2'h3;
  // reset value and baud divider limit
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [2:0] POSTDIV_MAX = 3'h5;
  // timing
  localparam int SYS_CLK_MHZ     = 40;
  localparam int PRESET_IDLE_US  = 100;
  localparam int PRESET_IDLE_CYC = PRESET_IDLE_US * SYS_CLK_MHZ;
endpackage

// >>> subghz_tx_host_interface.sv
// host side of the sub-GHz transmitter: preset pin, two-wire bus, serial port
// assumes all pins already synchronous to i_sys_clk; pad logic resolves sda
`timescale 1ns/100ps
// Behaviour
// - every register is eight bits wide and written or read whole, so any bit group can be changed.
// - addresses 0x14, 0x15, 0x16, 0x1b, 0x1c and 0x1d are read only, 0x12 is the FIFO window and reads zero, all others read and write.
// - in preset mode activity on the data pin wakes the transmitter and a long quiet low puts it to sleep.
// - a high data level turns the amplifier on for ASK or picks mark for FSK, low turns it off or picks space.
// - the data pin is sent as raw NRZ with no coding added.
// - in two-wire mode the data pin serves as the bus data line.
// - in two-wire mode the host fills the FIFO over the bus and the block sends it bit by bit.
// - FIFO bits leave as NRZ at the rate of the baud divider registers.
// - FIFO transmission stops at the packet length or at once on FIFO underflow or overflow.
// - the two-wire port answers address byte 0xd2 for writes and 0xd3 for reads.
// - the serial port works three-wire write only or four-wire with read data on its own output.
// - with transmit enabled and select low, the data pin modulates directly.
// - select going high ends transmission and enters the chosen power-down state.
// - power-down select 00 is shutdown, 01 standby, 10 program mode.
module subghz_tx_host_interface
  import subghz_tx_pkg::*;
#(
  parameter int         FIFO_DEPTH = 16,
  parameter logic [7:0] CHIP_ID    = 8'h5a, // arbitrary value
  parameter logic [7:0] CHIP_REV   = 8'h01  // arbitrary value
) (
  input  wire        i_sys_clk,
  input  wire        i_sys_rst,
  input  bus_mode_t  i_bus_mode,
  input  wire        i_spi_four_wire,
  input  wire        i_preset_fsk,
  input  wire        i_tx_data_pin,
  input  wire        i_scl,
  input  wire        i_sclk,
  input  wire        i_spi_select_n,
  input  wire        i_spi_sdi,
  output logic       o_sda_oe,
  output logic       o_sda_out,
  output logic       o_spi_sdo,
  output logic       o_spi_sdo_oe,
  output logic       o_pa_enable,
  output logic       o_fsk_mark,
  output logic       o_tx_active,
  output logic [1:0] o_power_mode,
  output logic [2:0] o_amp_power_level
);
  localparam int PW = $clog2(FIFO_DEPTH);

  // refuse depths the pointers and readback cannot serve
  generate
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("FIFO_DEPTH must be a power of two from 2 to 128");
    end
  endgenerate

  logic           scl_q, sda_q, sclk_q, sel_q;
  logic [7:0]     regs_reg [0:31];
  logic [7:0]     fifo_mem [0:FIFO_DEPTH-1];
  logic [PW:0]    wr_ptr_reg, rd_ptr_reg;
  logic           ser_active_reg, under_reg, over_reg;
  logic [7:0]     ser_shift_reg, bytes_sent_reg, pre_cnt_reg;
  logic [2:0]     ser_bit_reg;
  logic [6:0]     post_cnt_reg;
  logic           preset_active_reg;
  logic [11:0]    idle_cnt_reg;
  i2c_state_t     i2c_state_reg;
  logic [3:0]     i2c_bit_reg, spi_bit_reg;
  logic [7:0]     i2c_shift_reg, i2c_out_reg, spi_shift_reg, spi_out_reg;
  logic [4:0]     i2c_ptr_reg, spi_addr_reg;
  logic           i2c_first_reg, i2c_match_reg, i2c_rw_reg, i2c_nack_reg, spi_read_reg;

  // mode and pin edge decode
  wire mode_pre  = i_bus_mode == MODE_PRESET;
  wire mode_i2c  = i_bus_mode == MODE_I2C;
  wire mode_spi  = i_bus_mode == MODE_SPI;
  wire scl_rise  = mode_i2c & i_scl & ~scl_q;
  wire scl_fall  = mode_i2c & ~i_scl & scl_q;
  wire i2c_start = mode_i2c & i_scl & scl_q & sda_q & ~i_tx_data_pin;
  wire i2c_stop  = mode_i2c & i_scl & scl_q & ~sda_q & i_tx_data_pin;
  wire sclk_rise = mode_spi & ~i_spi_select_n & i_sclk & ~sclk_q;
  wire sclk_fall = mode_spi & ~i_spi_select_n & ~i_sclk & sclk_q;
  wire sel_rise  = mode_spi & i_spi_select_n & ~sel_q;

  // pin history
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      sclk_q <= 1'b0;
      sel_q  <= 1'b1;
    end else begin
      scl_q  <= i_scl;
      sda_q  <= i_tx_data_pin;
      sclk_q <= i_sclk;
      sel_q  <= i_spi_select_n;
    end
  end

  // fifo level decode
  wire [PW:0] fifo_count = wr_ptr_reg - rd_ptr_reg;
  wire        fifo_empty = fifo_count == '0;
  wire        fifo_full  = fifo_count == (PW + 1)'(FIFO_DEPTH);

  // read-only address decode
  function automatic logic is_ro(input logic [4:0] a);
    is_ro = (a == ADDR_RB_A) | (a == ADDR_RB_B) | (a == ADDR_RB_C) |
            (a == ADDR_ID) | (a == ADDR_REV) | (a == ADDR_STATUS);
  endfunction

  // read value for both serial ports
  function automatic logic [7:0] reg_value(input logic [4:0] a);
    case (a)
      ADDR_RB_A:     reg_value = 8'(fifo_count);
      ADDR_RB_B:     reg_value = bytes_sent_reg;
      ADDR_RB_C:     reg_value = {5'h00, ser_bit_reg};
      ADDR_ID:       reg_value = CHIP_ID;
      ADDR_REV:      reg_value = CHIP_REV;
      ADDR_STATUS:   reg_value = {3'h0, fifo_full, fifo_empty, over_reg, under_reg, o_tx_active};
      ADDR_FIFO_WIN: reg_value = 8'h00;
      default:       reg_value = regs_reg[a];
    endcase
  endfunction

  // two-wire byte framing
  wire        byte_done = scl_fall & (i2c_bit_reg == 4'h7);
  wire        ack_end   = scl_fall & (i2c_bit_reg == 4'h8);
  wire        addr_hit  = (i2c_shift_reg == I2C_ADDR_WR) | (i2c_shift_reg == I2C_ADDR_RD);
  wire        i2c_wr    = byte_done & (i2c_state_reg == I2C_WRITE) & ~i2c_first_reg;
  wire        i2c_load  = ack_end & (((i2c_state_reg == I2C_ADDR) & i2c_match_reg & i2c_rw_reg) |
                                     ((i2c_state_reg == I2C_READ) & ~i2c_nack_reg));
  wire [7:0]  i2c_rd    = reg_value(i2c_ptr_reg);

  // serial port framing: command byte {read, xx, addr}, then data byte
  wire        spi_cmd   = sclk_rise & (spi_bit_reg == 4'h7);
  wire        spi_wr    = sclk_rise & (spi_bit_reg == 4'hf) & ~spi_read_reg;
  wire        spi_load  = sclk_fall & (spi_bit_reg == 4'h8) & spi_read_reg & i_spi_four_wire;
  wire [7:0]  spi_rd    = reg_value(spi_addr_reg);

  // register write merge
  wire        wr_req    = i2c_wr | spi_wr;
  wire [4:0]  wr_addr   = i2c_wr ? i2c_ptr_reg : spi_addr_reg;
  wire [7:0]  wr_data   = i2c_wr ? i2c_shift_reg : {spi_shift_reg[6:0], i_spi_sdi};
  wire        wr_commit = wr_req & ~is_ro(wr_addr) & (wr_addr != ADDR_FIFO_WIN);
  wire [7:0]  wr_old    = regs_reg[wr_addr];
  wire        fifo_push = wr_req & (wr_addr == ADDR_FIFO_WIN) & mode_i2c;
  wire        status_clr = (i2c_load & (i2c_ptr_reg == ADDR_STATUS)) |
                           (spi_load & (spi_addr_reg == ADDR_STATUS));

  // baud divider decode
  wire [7:0]  prediv    = regs_reg[ADDR_BAUD_PRE];
  wire [2:0]  post_raw  = regs_reg[ADDR_BAUD_POST][2:0];
  wire [2:0]  post_sel  = (post_raw > POSTDIV_MAX) ? POSTDIV_MAX : post_raw;
  wire [6:0]  post_lim  = 7'((8'h02 << post_sel) - 8'h01);
  wire        pre_tick  = pre_cnt_reg == prediv;
  wire        baud_tick = ser_active_reg & pre_tick & (post_cnt_reg == post_lim);

  // fifo serializer control
  wire        over_evt  = fifo_push & fifo_full;
  wire        tx_event  = baud_tick & (ser_bit_reg == 3'h0);
  wire        last_byte = (bytes_sent_reg + 8'h01) == regs_reg[ADDR_PKT_LEN];
  wire        under_evt = tx_event & ~last_byte & fifo_empty;
  wire        ser_stop  = (over_evt & ser_active_reg) | (tx_event & (last_byte | fifo_empty));
  wire        ser_start = mode_i2c & ~ser_active_reg & ~fifo_empty & ~over_evt;
  wire        fifo_pop  = ser_start | (tx_event & ~last_byte & ~fifo_empty);

  // modulation source and power state
  wire        txen_any  = regs_reg[ADDR_TXEN_A][TXEN_BIT] | regs_reg[ADDR_TXEN_B][TXEN_BIT];
  wire        spi_tx_on = mode_spi & ~i_spi_select_n & txen_any;
  wire        mod_bit   = mode_i2c ? ser_shift_reg[7] : i_tx_data_pin;
  wire        tx_on     = mode_pre ? preset_active_reg : (mode_i2c ? ser_active_reg : spi_tx_on);
  wire        fsk_sel   = mode_pre ? i_preset_fsk : regs_reg[ADDR_BASE_CFG][MOD_FSK_BIT];
  wire [1:0]  pwr_next  = tx_on ? PWR_TRANSMIT :
                          (mode_pre ? PWR_SHUTDOWN : regs_reg[ADDR_PWR_DOWN][1:0]);

  // register file; enable bits drop when select rises
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 32; i++) begin
        regs_reg[i] <= REG_RESET;
      end
    end else begin
      if (wr_commit) begin
        regs_reg[wr_addr] <= wr_data;
      end
      if (sel_rise) begin
        regs_reg[ADDR_TXEN_A][TXEN_BIT] <= 1'b0;
        regs_reg[ADDR_TXEN_B][TXEN_BIT] <= 1'b0;
      end
    end
  end

  // fifo storage and pointers; a stop flushes what is left
  always_ff @(posedge i_sys_clk) begin
    if (fifo_push & ~fifo_full) begin
      fifo_mem[wr_ptr_reg[PW-1:0]] <= wr_data;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (fifo_push & ~fifo_full) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (ser_stop) begin
        rd_ptr_reg <= wr_ptr_reg;
      end else if (fifo_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  // baud divider: prescale then power-of-two postscale
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_cnt_reg  <= 8'h00;
      post_cnt_reg <= 7'h00;
    end else if (~ser_active_reg) begin
      pre_cnt_reg  <= 8'h00;
      post_cnt_reg <= 7'h00;
    end else begin
      pre_cnt_reg  <= pre_tick ? 8'h00 : pre_cnt_reg + 8'h01;
      if (pre_tick) begin
        post_cnt_reg <= (post_cnt_reg == post_lim) ? 7'h00 : post_cnt_reg + 7'h01;
      end
    end
  end

  // nrz serializer, msb first
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ser_active_reg <= 1'b0;
      ser_shift_reg  <= 8'h00;
      ser_bit_reg    <= 3'h0;
      bytes_sent_reg <= 8'h00;
    end else if (ser_stop) begin
      ser_active_reg <= 1'b0;
    end else if (fifo_pop) begin
      ser_active_reg <= 1'b1;
      ser_shift_reg  <= fifo_mem[rd_ptr_reg[PW-1:0]];
      ser_bit_reg    <= 3'h7;
      bytes_sent_reg <= ser_start ? 8'h00 : bytes_sent_reg + 8'h01;
    end else if (baud_tick) begin
      ser_shift_reg  <= {ser_shift_reg[6:0], 1'b0};
      ser_bit_reg    <= ser_bit_reg - 3'h1;
    end
  end

  // sticky error flags, a new event beats the read clear
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      under_reg <= 1'b0;
      over_reg  <= 1'b0;
    end else begin
      under_reg <= under_evt | (under_reg & ~status_clr);
      over_reg  <= over_evt | (over_reg & ~status_clr);
    end
  end

  // preset activity detection: high wakes, a long low sleeps
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      preset_active_reg <= 1'b0;
      idle_cnt_reg      <= 12'h000;
    end else if (~mode_pre | i_tx_data_pin) begin
      preset_active_reg <= mode_pre;
      idle_cnt_reg      <= 12'h000;
    end else if (preset_active_reg) begin
      idle_cnt_reg      <= idle_cnt_reg + 12'h001;
      if (idle_cnt_reg == 12'(PRESET_IDLE_CYC - 1)) begin
        preset_active_reg <= 1'b0;
      end
    end
  end

  // two-wire slave: bits taken on scl rise, driven after scl fall
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      i2c_state_reg <= I2C_IDLE;
      i2c_bit_reg   <= 4'h0;
      i2c_shift_reg <= 8'h00;
      i2c_out_reg   <= 8'h00;
      i2c_ptr_reg   <= 5'h00;
      i2c_first_reg <= 1'b0;
      i2c_match_reg <= 1'b0;
      i2c_rw_reg    <= 1'b0;
      i2c_nack_reg  <= 1'b0;
      o_sda_oe      <= 1'b0;
    end else if (~mode_i2c | i2c_stop) begin
      i2c_state_reg <= I2C_IDLE;
      o_sda_oe      <= 1'b0;
    end else if (i2c_start) begin
      i2c_state_reg <= I2C_ADDR;
      i2c_bit_reg   <= 4'hf; // the start's own scl fall wraps this to bit 0
      o_sda_oe      <= 1'b0;
    end else if (scl_rise) begin
      if (i2c_bit_reg == 4'h8) begin
        i2c_nack_reg  <= i_tx_data_pin;
      end else begin
        i2c_shift_reg <= {i2c_shift_reg[6:0], i_tx_data_pin};
      end
    end else if (scl_fall & (i2c_state_reg != I2C_IDLE)) begin
      i2c_bit_reg <= (i2c_bit_reg == 4'h8) ? 4'h0 : i2c_bit_reg + 4'h1;
      if (byte_done) begin
        unique case (i2c_state_reg)
          I2C_ADDR: begin
            i2c_match_reg <= addr_hit;
            i2c_rw_reg    <= i2c_shift_reg[0];
            o_sda_oe      <= addr_hit;
          end
          I2C_WRITE: begin
            o_sda_oe      <= 1'b1;
            i2c_first_reg <= 1'b0;
            if (i2c_first_reg) begin
              i2c_ptr_reg <= i2c_shift_reg[4:0];
            end else if (i2c_ptr_reg != ADDR_FIFO_WIN) begin
              i2c_ptr_reg <= i2c_ptr_reg + 5'h01;
            end
          end
          I2C_READ: o_sda_oe <= 1'b0;
          I2C_IDLE: o_sda_oe <= 1'b0;
        endcase
      end else if (ack_end) begin
        o_sda_oe <= i2c_load & ~i2c_rd[7];
        if (i2c_load) begin
          i2c_out_reg <= i2c_rd;
          i2c_ptr_reg <= i2c_ptr_reg + 5'h01;
        end
        if (i2c_state_reg == I2C_ADDR) begin
          i2c_state_reg <= ~i2c_match_reg ? I2C_IDLE : (i2c_rw_reg ? I2C_READ : I2C_WRITE);
          i2c_first_reg <= 1'b1;
        end else if ((i2c_state_reg == I2C_READ) & i2c_nack_reg) begin
          i2c_state_reg <= I2C_IDLE;
        end
      end else if (i2c_state_reg == I2C_READ) begin
        o_sda_oe    <= ~i2c_out_reg[6];
        i2c_out_reg <= {i2c_out_reg[6:0], 1'b0};
      end
    end
  end

  // serial port slave: sampled on sclk rise, read data shifted on fall
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      spi_bit_reg   <= 4'h0;
      spi_shift_reg <= 8'h00;
      spi_out_reg   <= 8'h00;
      spi_addr_reg  <= 5'h00;
      spi_read_reg  <= 1'b0;
      o_spi_sdo     <= 1'b0;
      o_spi_sdo_oe  <= 1'b0;
    end else begin
      o_spi_sdo_oe <= mode_spi & i_spi_four_wire & ~i_spi_select_n;
      if (i_spi_select_n) begin
        spi_bit_reg <= 4'h0;
      end else if (sclk_rise) begin
        spi_shift_reg <= {spi_shift_reg[6:0], i_spi_sdi};
        spi_bit_reg   <= spi_bit_reg + 4'h1;
        if (spi_cmd) begin
          spi_read_reg <= spi_shift_reg[6];
          spi_addr_reg <= {spi_shift_reg[3:0], i_spi_sdi};
        end
      end else if (spi_load) begin
        spi_out_reg <= spi_rd;
        o_spi_sdo   <= spi_rd[7];
      end else if (sclk_fall & (spi_bit_reg > 4'h8)) begin
        spi_out_reg <= {spi_out_reg[6:0], 1'b0};
        o_spi_sdo   <= spi_out_reg[6];
      end
    end
  end

  // modulation and status outputs
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pa_enable       <= 1'b0;
      o_fsk_mark        <= 1'b0;
      o_tx_active       <= 1'b0;
      o_power_mode      <= PWR_SHUTDOWN;
      o_amp_power_level <= 3'h0;
      o_sda_out         <= 1'b0;
    end else begin
      o_pa_enable       <= tx_on & (fsk_sel | mod_bit);
      o_fsk_mark        <= tx_on & fsk_sel & mod_bit;
      o_tx_active       <= tx_on;
      o_power_mode      <= pwr_next;
      o_amp_power_level <= regs_reg[ADDR_AMP][2:0];
      o_sda_out         <= 1'b0;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_addr_byte;
    (i2c_state_reg == I2C_ADDR) && byte_done && addr_hit;
  endsequence
  sequence s_spi_tx_end;
    spi_tx_on ##1 sel_rise;
  endsequence

  a_wr_stores_byte: assert property (wr_commit |=> regs_reg[$past(wr_addr)] == $past(wr_data))
    else $error("register write not stored");
  a_ro_not_stored: assert property (wr_req && is_ro(wr_addr) |=> regs_reg[$past(wr_addr)] == $past(wr_old))
    else $error("read-only register changed");
  a_preset_wakes: assert property (mode_pre && i_tx_data_pin |=> preset_active_reg ##1 o_tx_active)
    else $error("preset data did not wake");
  a_ask_follows_pin: assert property (mode_pre && !i_preset_fsk && preset_active_reg |=>
    o_pa_enable == $past(i_tx_data_pin))
    else $error("ask amplifier not following data");
  a_fsk_raw_nrz: assert property (mode_pre && i_preset_fsk && preset_active_reg |=>
    o_pa_enable && (o_fsk_mark == $past(i_tx_data_pin)))
    else $error("fsk mark not raw data");
  a_sda_only_i2c: assert property (!mode_i2c |=> !o_sda_oe)
    else $error("data pin driven outside two-wire mode");
  a_addr_acked: assert property ((mode_i2c and s_addr_byte) |=> o_sda_oe)
    else $error("own address not acknowledged");
  a_baud_period: assert property (ser_active_reg && baud_tick && post_sel == 3'h0 && prediv == 8'h03 |=>
    (!baud_tick [*7] ##1 (baud_tick || !ser_active_reg)))
    else $error("baud period wrong");
  a_len_stops_tx: assert property (mode_i2c && tx_event && last_byte |=> !ser_active_reg ##1 !o_tx_active)
    else $error("packet length did not stop");
  a_overflow_stops: assert property (ser_active_reg && over_evt |=> !ser_active_reg && over_reg)
    else $error("overflow did not stop");
  a_spi_stream: assert property (spi_tx_on && !fsk_sel |=> o_pa_enable == $past(i_tx_data_pin))
    else $error("serial-mode data not modulating");
  a_select_ends_tx: assert property (s_spi_tx_end |=> !o_tx_active &&
    (o_power_mode == regs_reg[ADDR_PWR_DOWN][1:0]))
    else $error("select high did not end transmit");
endmodule

// >>> mcu_host_model.sv
// host microcontroller model: serial port and two-wire bus master
// assumes a free-running system clock; every bus phase lasts four clocks
`timescale 1ns/100ps
module mcu_host_model (
  input  wire logic i_clk,
  input  wire logic i_sda_oe,
  input  wire logic i_sdo,
  output logic      o_scl,
  output logic      o_sclk,
  output logic      o_sel_n,
  output logic      o_sdi,
  output logic      o_sda
);
  // idle lines: clocks still, select released, sda released high
  initial begin
    o_scl   = 1'b1;
    o_sclk  = 1'b0;
    o_sel_n = 1'b1;
    o_sdi   = 1'b0;
    o_sda   = 1'b1;
  end
  // one bus phase, slow enough for the sampled pins
  task automatic half();
    repeat (4) @(negedge i_clk);
  endtask
  // select stays low through writes and the data stream
  task automatic set_sel(input logic v);
    o_sel_n = v;
    half();
  endtask
  // one 16-bit frame, msb first; read bits caught just before each rise
  task automatic spi_frame(input logic [15:0] f, output logic [7:0] rd);
    rd = 8'h00;
    for (int k = 15; k >= 0; k--) begin
      o_sdi = f[k];
      half();
      if (k < 8) rd[k] = i_sdo;
      o_sclk = 1'b1;
      half();
      o_sclk = 1'b0;
    end
    half(); // idle phase lets the last fall settle before the next frame
  endtask
  // one byte msb first, then a ninth clock with sda released; ack caught as scl rises
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    logic [8:0] f;
    f = {b, 1'b1};
    ack = 1'b0;
    for (int k = 8; k >= 0; k--) begin
      o_sda = f[k];
      half();
      o_scl = 1'b1;
      if (k == 0) ack = i_sda_oe;
      half();
      o_scl = 1'b0;
      half();
    end
  endtask
  // start, the low n bytes of b highest first, stop; returns the ack of the first byte
  task automatic i2c_seq(input logic [31:0] b, input int n, output logic ack);
    logic a;
    ack = 1'b0;
    o_sda = 1'b0;
    half();
    o_scl = 1'b0;
    half();
    for (int j = n - 1; j >= 0; j--) begin
      i2c_byte(b[8*j +: 8], a);
      if (j == n - 1) ack = a;
    end
    o_sda = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_sda = 1'b1;
    half();
  endtask
endmodule

// >>> subghz_tx_host_interface_bench.sv
// self-checking bench for the transmitter host block
// assumes the host model drives bus pins; inputs change at the falling edge
`timescale 1ns/100ps
module subghz_tx_host_interface_bench
  import subghz_tx_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, four = 1'b1, fsk = 1'b0, pin = 1'b0, ack;
  bus_mode_t   mode = MODE_PRESET;
  logic        sda_oe, sda_o, sdo, sdo_oe, pa, mark, tx, scl, sclk, sel_n, sdi, sda;
  logic [1:0]  pm;
  logic [2:0]  amp, amp_x = 3'h0;
  logic [7:0]  rd;
  logic [8:0]  exp_v, obs_v;
  logic [8:0]  exp_q[$];
  logic [31:0] rnd = 32'h00014c5e;
  logic [4:0]  ro_a[6] = '{ADDR_RB_A, ADDR_RB_B, ADDR_RB_C, ADDR_ID, ADDR_REV, ADDR_STATUS};
  logic [7:0]  ro_e[6] = '{8'h00, 8'h00, 8'h00, 8'h3c, 8'h07, 8'h08};
  logic [7:0]  i2c_a[3] = '{8'hd4, I2C_ADDR_WR, I2C_ADDR_RD};
  logic        i2c_e[3] = '{1'b0, 1'b1, 1'b1};
  int          errors = 0, checked = 0;
  event        got;
  // data pin doubles as the open-drain sda wire in two-wire mode
  wire         data_pin = (mode == MODE_I2C) ? (sda & (sda_o | ~sda_oe)) : pin;
  always #12.5 clk = ~clk;
  subghz_tx_host_interface #(.CHIP_ID(8'h3c), .CHIP_REV(8'h07)) subghz_tx_host_interface_inst (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_bus_mode(mode), .i_spi_four_wire(four), .i_preset_fsk(fsk),
    .i_tx_data_pin(data_pin), .i_scl(scl), .i_sclk(sclk), .i_spi_select_n(sel_n), .i_spi_sdi(sdi),
    .o_sda_oe(sda_oe), .o_sda_out(sda_o), .o_spi_sdo(sdo), .o_spi_sdo_oe(sdo_oe), .o_pa_enable(pa),
    .o_fsk_mark(mark), .o_tx_active(tx), .o_power_mode(pm), .o_amp_power_level(amp));
  // a released sdo line floats up to its pull-up level
  mcu_host_model mcu_host_model_inst (.i_clk(clk), .i_sda_oe(sda_oe), .i_sdo(sdo_oe ? sdo : 1'b1), .o_scl(scl),
    .o_sclk(sclk), .o_sel_n(sel_n), .o_sdi(sdi), .o_sda(sda));
  // monitor: oldest note against the read byte or the output vector
  always @(got) begin
    exp_v = exp_q.pop_front();
    obs_v = exp_v[8] ? {1'b1, rd} : {1'b0, pa, mark, tx, pm, amp};
    checked++;
    if (obs_v !== exp_v) begin
      errors++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, exp_v, obs_v);
    end
  end
  task automatic note(input logic [8:0] v);
    exp_q.push_back(v);
    -> got;
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // random nrz bits on the data pin, first bit high to wake the transmitter
  task automatic drive_bits();
    for (int k = 0; k < 12; k++) begin
      rnd = lfsr_next(rnd);
      pin = (k == 0) | rnd[0];
      repeat (2) @(negedge clk);
      note({1'b0, fsk | pin, fsk & pin, 1'b1, 2'h3, amp_x});
    end
  endtask
  task automatic spi_wr(input logic [4:0] a, input logic [7:0] d);
    mcu_host_model_inst.spi_frame({3'h0, a, d}, rd);
  endtask
  task automatic spi_chk(input logic [4:0] a, input logic [7:0] e);
    mcu_host_model_inst.spi_frame({3'h4, a, 8'h00}, rd);
    note({1'b1, e});
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog bounds the whole run
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    stop_test();
  end
  // main sequence: preset, serial port, fifo, two-wire address
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    note(9'h000);
    drive_bits();
    fsk = 1'b1;
    drive_bits();
    pin = 1'b1;
    @(negedge clk);
    pin = 1'b0;
    repeat (3990) @(negedge clk);
    note({4'h5, 2'h3, amp_x});
    repeat (20) @(negedge clk);
    note({6'h00, amp_x});
    $display("preset test done");
    fsk = 1'b0;
    mode = MODE_SPI;
    mcu_host_model_inst.set_sel(1'b0);
    spi_wr(ADDR_AMP, 8'h07);
    amp_x = 3'h7;
    foreach (ro_a[i]) begin
      spi_wr(ro_a[i], 8'hff);
      spi_chk(ro_a[i], ro_e[i]);
    end
    spi_chk(ADDR_AMP, 8'h07);
    four = 1'b0;
    spi_wr(ADDR_AMP, 8'h05);
    amp_x = 3'h5;
    spi_chk(ADDR_AMP, 8'hff);
    four = 1'b1;
    spi_chk(ADDR_AMP, 8'h05);
    for (int m = 0; m < 3; m++) begin
      spi_wr(ADDR_PWR_DOWN, 8'(m));
      spi_wr(m[0] ? ADDR_TXEN_B : ADDR_TXEN_A, 8'h01);
      drive_bits();
      mcu_host_model_inst.set_sel(1'b1);
      note({4'h0, 2'(m), amp_x});
      mcu_host_model_inst.set_sel(1'b0);
    end
    $display("serial port test done");
    mode = MODE_I2C;
    repeat (8) @(negedge clk);
    // baud of eight clocks per bit, one-byte packet, then one random byte into the fifo
    mcu_host_model_inst.i2c_seq({I2C_ADDR_WR, 3'h0, ADDR_BAUD_POST, 8'h00, 8'h03}, 4, ack);
    mcu_host_model_inst.i2c_seq({8'h00, I2C_ADDR_WR, 3'h0, ADDR_PKT_LEN, 8'h01}, 3, ack);
    rnd = lfsr_next(rnd);
    fork
      mcu_host_model_inst.i2c_seq({8'h00, I2C_ADDR_WR, 3'h0, ADDR_FIFO_WIN, rnd[7:0]}, 3, ack);
      begin
        for (int w = 0; w < 600 && !tx; w++) begin
          @(negedge clk);
        end
        if (!tx) begin
          errors++;
          stop_test();
        end else begin
          repeat (4) @(negedge clk);
          for (int k = 7; k >= 0; k--) begin
            note({1'b0, rnd[k], 1'b0, 1'b1, 2'h3, amp_x});
            repeat (8) @(negedge clk);
          end
          note({4'h0, PWR_PROGRAM, amp_x});
        end
      end
    join
    $display("fifo test done");
    foreach (i2c_a[i]) begin
      mcu_host_model_inst.i2c_seq({24'h000000, i2c_a[i]}, 1, ack);
      rd = {7'h00, ack};
      note({1'b1, 7'h00, i2c_e[i]});
    end
    $display("two-wire test done");
    stop_test();
  end
endmodule
